// ===== rtl/lpms_pkg.sv
// package: power-mode supervisor types and constants
package lpms_pkg;

    localparam int LPMS_WAKEUP_PIN_PINS = 16;
    localparam int LPMS_NUM_IO    = 16;
    localparam int LPMS_NUM_SRAM  = 2;
    localparam int LPMS_NUM_AUTO  = 6;

    // autonomous peripheral slot index
    localparam int LPMS_AP_UART   = 0;
    localparam int LPMS_AP_I2C    = 1;
    localparam int LPMS_AP_SPI    = 2;
    localparam int LPMS_AP_ADC    = 3;
    localparam int LPMS_AP_LOW_POWER_TIMER  = 4;
    localparam int LPMS_AP_DMA    = 5;

    // after-reset values
    localparam logic [2:0] LPMS_RST_MODE = 3'h0;
    localparam logic       LPMS_RST_OPT  = 1'h0;
    localparam logic [1:0] LPMS_RST_VOS  = 2'h0;

    // retention pull selection per pin
    localparam logic [1:0] LPMS_PULL_FLOAT = 2'h0;
    localparam logic [1:0] LPMS_PULL_UP    = 2'h1;
    localparam logic [1:0] LPMS_PULL_DOWN  = 2'h2;

    typedef enum logic [5:0] {
        LPMS_RUN      = 6'h01,
        LPMS_SLEEP    = 6'h02,
        LPMS_STOP0    = 6'h04,
        LPMS_STOP1    = 6'h08,
        LPMS_STBY_RET = 6'h10,
        LPMS_STBY     = 6'h20
    } lpms_mode_type;

    // low-power mode request codes
    localparam logic [2:0] LPMS_SEL_SLEEP    = 3'h1;
    localparam logic [2:0] LPMS_SEL_STOP0    = 3'h2;
    localparam logic [2:0] LPMS_SEL_STOP1    = 3'h3;
    localparam logic [2:0] LPMS_SEL_STBY_RET = 3'h4;
    localparam logic [2:0] LPMS_SEL_STBY     = 3'h5;

    // software write port for power settings
    typedef struct packed {
        logic        wr;
        logic        secure;
        logic [2:0]  lp_mode;
        logic [15:0] wakeup_pin_en;
        logic        pvd_en;
        logic        bkp_en;
        logic [1:0]  voltage_scaling_select;
        logic        flash_pd;
        logic [1:0]  sram_on;
        logic [15:0] ret_en;
        logic [31:0] ret_pull;
        logic [LPMS_NUM_AUTO-1:0] auto_en;
    } lpms_cfg_type;

    // per-peripheral autonomous status
    typedef struct packed {
        logic [LPMS_NUM_AUTO-1:0] run;
        logic [LPMS_NUM_AUTO-1:0] wake;
    } lpms_auto_type;

endpackage : lpms_pkg

// ===== rtl/lpms_osc_req.sv
// oscillator on-demand request arbiter
`timescale 1ns/1ps

module lpms_osc_req
    import lpms_pkg::*;
#(
    parameter int N = 6
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [N-1:0] i_req,
    input  wire logic         i_allow,
    output logic              o_osc_on
);
    if (N < 1) begin : g_bad_n
        $error("lpms_osc_req: N must be at least 1");
    end

    wire any_req = i_allow && (|i_req);

    // on while i_allow is high and any requester holds it, off on the next clock when none do
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_osc_on <= 1'b0;
        else          o_osc_on <= any_req; // RQ1 RQ2
    end

    osc_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ1
        any_req |=> o_osc_on) else $error("oscillator not started on request");
    osc_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ2
        !any_req |=> !o_osc_on) else $error("oscillator not released");

endmodule : lpms_osc_req

// ===== rtl/lpms_supervisor.sv
// power-mode availability and security supervisor
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// (RQ1) autonomous stop-wake peripheral requests start the 16 MHz RC; none request, it stops
// (RQ2) radio request holds the 32 MHz crystal on outside standby; release turns it off
// (RQ3) in standby each io keeps its level by pull-up, pull-down or floating
// (RQ4) sixteen wake-up pins can bring the device out of standby
// (RQ5) uarts run and wake the device in stop modes
// (RQ6) i2c units run and wake the device in stop modes
// (RQ7) spi units run and wake the device in stop modes
// (RQ8) adc converts and wakes the device in stop modes
// (RQ9) low-power timers run and wake the device in stop modes
// (RQ10) dma runs and wakes in light stop only; deep stop retains it
// (RQ11) debug unit reachable through access port zero in both stop modes
// (RQ12) in standby, debug reachable only while debugger powerup request is held
// (RQ13) during and after reset all ios analog, schmitt trigger off
// (RQ14) internal reset source disables the reset pin pull-up
// (RQ15) security option makes mode, wake pins, detection, backup secure-only
// (RQ16) voltage scaling is secure when system clock selection is secure
// (RQ17) io retention setting secure when its gpio pin is secure
// (RQ18) optional functions are off after reset until software enables them
// (RQ19) flash normal by default, power-down in low-power modes if configured; the code keeps flash on in sleep
// (RQ20) each sram block has its own independent power switch
// (RQ21) parity error or nmi can wake the device from stop
// (RQ22) non-secure writes to secure settings ignored, reads return zero
module lpms_supervisor
    import lpms_pkg::*;
#(
    parameter int NUM_IO = LPMS_NUM_IO
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire lpms_cfg_type             i_cfg,
    input  wire logic                     i_rd_secure,
    input  wire logic                     i_security_enable_option,
    input  wire logic                     i_sysclk_sel_secure,
    input  wire logic [NUM_IO-1:0]        i_gpio_secure,
    input  wire logic                     i_sleep_req,
    input  wire logic                     i_sw_wake,
    input  wire logic [LPMS_NUM_AUTO-1:0] i_auto_osc_req,
    input  wire logic [LPMS_NUM_AUTO-1:0] i_auto_event,
    input  wire logic                     i_radio_auto_req,
    input  wire logic [15:0]              i_wakeup_pin,
    input  wire logic                     i_parity_err,
    input  wire logic                     i_nmi,
    input  wire logic                     i_debugger_powerup_request,
    input  wire logic                     i_reset_internal,
    output lpms_mode_type                 o_mode,
    output logic                          o_internal_rc_osc_16m_on,
    output logic                          o_external_xtal_osc_32m_on,
    output lpms_auto_type                 o_auto,
    output logic                          o_dma_retained,
    output logic                          o_debug_ap0_reachable,
    output logic [NUM_IO-1:0]             o_io_analog,
    output logic [NUM_IO-1:0]             o_io_schmitt_en,
    output logic [NUM_IO-1:0]             o_io_pull_up,
    output logic [NUM_IO-1:0]             o_io_pull_down,
    output logic                          o_reset_pin_pullup_en,
    output logic                          o_flash_pd,
    output logic [LPMS_NUM_SRAM-1:0]      o_sram_on,
    output lpms_cfg_type                  o_rd
);
    if (NUM_IO != 16) begin : g_bad_io
        $error("lpms_supervisor: NUM_IO must be 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // stored settings
    logic [2:0]                lp_mode;
    logic [15:0]               wakeup_pin_en;
    logic                      pvd_en;
    logic                      bkp_en;
    logic [1:0]                voltage_scaling_select;
    logic                      flash_pd;
    logic [1:0]                sram_on;
    logic [NUM_IO-1:0]         ret_en;
    logic [2*NUM_IO-1:0]       ret_pull;
    logic [LPMS_NUM_AUTO-1:0]  auto_en;
    logic                      ios_configured;
    lpms_mode_type             mode;
    lpms_mode_type             next_mode;

    // security gating of individual fields
    wire tz        = i_security_enable_option;
    wire ns_ok     = i_cfg.secure || !tz;                    // RQ15
    wire vos_ok    = i_cfg.secure || !i_sysclk_sel_secure;   // RQ16
    wire wr        = i_cfg.wr;
    wire [NUM_IO-1:0] io_sec = i_gpio_secure;

    // per-pin write mask for retention, secure pin refuses non-secure write
    wire [NUM_IO-1:0] ret_wmask = i_cfg.secure ? {NUM_IO{1'b1}} : ~io_sec; // RQ17
    wire [NUM_IO-1:0] next_ret_en = (ret_en & ~ret_wmask) | (i_cfg.ret_en & ret_wmask);

    function automatic logic [2*NUM_IO-1:0] spread(input logic [NUM_IO-1:0] m);
        logic [2*NUM_IO-1:0] r;
        r = '0;
        for (int k = 0; k < NUM_IO; k++) begin
            r[2*k +: 2] = {m[k], m[k]};
        end
        return r;
    endfunction : spread

    wire [2*NUM_IO-1:0] pull_m = spread(ret_wmask);
    wire [2*NUM_IO-1:0] next_ret_pull = (ret_pull & ~pull_m) | (i_cfg.ret_pull & pull_m);

    // settings; optional functions all start disabled
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lp_mode  <= LPMS_RST_MODE;
            wakeup_pin_en  <= '0;
            pvd_en   <= LPMS_RST_OPT;
            bkp_en   <= LPMS_RST_OPT;
            voltage_scaling_select      <= LPMS_RST_VOS;
            flash_pd <= LPMS_RST_OPT;   // RQ19
            sram_on  <= '0;             // RQ18
            ret_en   <= '0;
            ret_pull <= '0;
            auto_en  <= '0;             // RQ18
        end else if (wr) begin
            if (ns_ok) begin            // RQ22
                lp_mode <= i_cfg.lp_mode;
                wakeup_pin_en <= i_cfg.wakeup_pin_en;
                pvd_en  <= i_cfg.pvd_en;
                bkp_en  <= i_cfg.bkp_en;
            end
            if (vos_ok) voltage_scaling_select <= i_cfg.voltage_scaling_select; // RQ16
            flash_pd <= i_cfg.flash_pd;
            sram_on  <= i_cfg.sram_on;    // RQ20
            ret_en   <= next_ret_en;      // RQ17
            ret_pull <= next_ret_pull;
            auto_en  <= i_cfg.auto_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read-back, secure fields read zero to non-secure readers
    wire rd_ok  = i_rd_secure || !tz;
    wire rv_ok  = i_rd_secure || !i_sysclk_sel_secure;
    wire [NUM_IO-1:0] rd_io = i_rd_secure ? {NUM_IO{1'b1}} : ~io_sec;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_rd <= '0;
        else begin
            o_rd.wr       <= 1'b0;
            o_rd.secure   <= i_rd_secure;
            o_rd.lp_mode  <= rd_ok ? lp_mode : 3'h0;  // RQ22
            o_rd.wakeup_pin_en  <= rd_ok ? wakeup_pin_en : 16'h0000;
            o_rd.pvd_en   <= rd_ok && pvd_en;
            o_rd.bkp_en   <= rd_ok && bkp_en;
            o_rd.voltage_scaling_select      <= rv_ok ? voltage_scaling_select : 2'h0;
            o_rd.flash_pd <= flash_pd;
            o_rd.sram_on  <= sram_on;
            o_rd.ret_en   <= ret_en & rd_io;
            o_rd.ret_pull <= ret_pull & spread(rd_io);
            o_rd.auto_en  <= auto_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake sources
    wire in_stop  = (mode == LPMS_STOP0) || (mode == LPMS_STOP1);
    wire in_stby  = (mode == LPMS_STBY) || (mode == LPMS_STBY_RET);
    wire [LPMS_NUM_AUTO-1:0] stop_ok;
    // in stop modes dma only runs in stop0; others in both stops
    assign stop_ok = in_stop ? {mode == LPMS_STOP0, {(LPMS_NUM_AUTO-1){1'b1}}}
                             : {LPMS_NUM_AUTO{1'b1}}; // RQ10
    wire [LPMS_NUM_AUTO-1:0] auto_act  = auto_en & stop_ok & ~{LPMS_NUM_AUTO{in_stby}};
    wire [LPMS_NUM_AUTO-1:0] auto_wake = auto_act & i_auto_event & {LPMS_NUM_AUTO{in_stop}};
    wire stop_wake = (|auto_wake) || i_parity_err || i_nmi || i_sw_wake; // RQ5 RQ6 RQ7 RQ8 RQ9 RQ21
    wire stby_wake = |(i_wakeup_pin & wakeup_pin_en) || i_sw_wake;               // RQ4

    // mode sequencer
    always_comb begin
        next_mode = mode;
        unique case (mode)
            LPMS_RUN: begin
                if (i_sleep_req) begin
                    unique case (lp_mode)
                        LPMS_SEL_STOP0:    next_mode = LPMS_STOP0;
                        LPMS_SEL_STOP1:    next_mode = LPMS_STOP1;
                        LPMS_SEL_STBY_RET: next_mode = LPMS_STBY_RET;
                        LPMS_SEL_STBY:     next_mode = LPMS_STBY;
                        default:           next_mode = LPMS_SLEEP;
                    endcase
                end
            end
            LPMS_SLEEP: begin
                if (!i_sleep_req || i_sw_wake) next_mode = LPMS_RUN;
            end
            LPMS_STOP0, LPMS_STOP1: begin
                if (stop_wake) next_mode = LPMS_RUN;
            end
            LPMS_STBY_RET, LPMS_STBY: begin
                if (stby_wake) next_mode = LPMS_RUN;
            end
            default: next_mode = LPMS_RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) mode <= LPMS_RUN;
        else          mode <= next_mode;
    end
    assign o_mode = mode;

    ////////////////////////////////////////////////////////////////////////////
    // oscillators: rc follows stop-capable peripherals, crystal follows radio
    lpms_osc_req #(.N(LPMS_NUM_AUTO)) u_rc16 (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_req    (i_auto_osc_req & auto_act),
        .i_allow  (1'b1),
        .o_osc_on (o_internal_rc_osc_16m_on)
    ); // RQ1

    lpms_osc_req #(.N(1)) u_xo32 (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_req    (i_radio_auto_req),
        .i_allow  (!in_stby),
        .o_osc_on (o_external_xtal_osc_32m_on)
    ); // RQ2

    ////////////////////////////////////////////////////////////////////////////
    // registered status outputs
    wire dbg_ok = in_stby ? i_debugger_powerup_request : 1'b1; // RQ11 RQ12
    wire in_lp  = mode != LPMS_RUN && mode != LPMS_SLEEP;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_auto                <= '0;
            o_dma_retained        <= 1'b0;
            o_debug_ap0_reachable <= 1'b0;
            o_flash_pd            <= 1'b0;
            o_sram_on             <= '0;
            o_reset_pin_pullup_en <= 1'b1;
            ios_configured        <= 1'b0;
        end else begin
            o_auto.run            <= auto_act;
            o_auto.wake           <= auto_wake;
            o_dma_retained        <= mode == LPMS_STOP1; // RQ10
            o_debug_ap0_reachable <= dbg_ok;
            o_flash_pd            <= flash_pd && in_lp;  // RQ19
            o_sram_on             <= sram_on;            // RQ20
            o_reset_pin_pullup_en <= !i_reset_internal;  // RQ14
            ios_configured        <= ios_configured || wr; // RQ13
        end
    end

    // ios analog until software first writes; retention pulls in standby
    wire [NUM_IO-1:0] pu_sel;
    wire [NUM_IO-1:0] pd_sel;
    for (genvar g = 0; g < NUM_IO; g++) begin : g_pull
        assign pu_sel[g] = ret_en[g] && ret_pull[2*g +: 2] == LPMS_PULL_UP;
        assign pd_sel[g] = ret_en[g] && ret_pull[2*g +: 2] == LPMS_PULL_DOWN;
    end
    assign o_io_analog     = {NUM_IO{!ios_configured}};            // RQ13
    assign o_io_schmitt_en = {NUM_IO{ios_configured}};             // RQ13
    assign o_io_pull_up    = in_stby ? pu_sel : {NUM_IO{1'b0}};     // RQ3
    assign o_io_pull_down  = in_stby ? pd_sel : {NUM_IO{1'b0}};     // RQ3

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sec_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ15
        (wr && tz && !i_cfg.secure) |=> $stable(lp_mode) && $stable(wakeup_pin_en))
        else $error("non-secure write changed secure setting");
    vos_sec_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ16
        (wr && i_sysclk_sel_secure && !i_cfg.secure) |=> $stable(voltage_scaling_select))
        else $error("voltage scaling changed by non-secure write");
    ret_sec_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ17
        (wr && !i_cfg.secure) |=> ((ret_en ^ $past(ret_en)) & $past(io_sec)) == '0)
        else $error("secure pin retention changed");
    rd_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ22
        (tz && !i_rd_secure) |=> o_rd.lp_mode == 3'h0 && o_rd.wakeup_pin_en == 16'h0000)
        else $error("secure field leaked to non-secure read");
    dbg_stby_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ12
        (in_stby && !i_debugger_powerup_request) |=> !o_debug_ap0_reachable)
        else $error("debug reachable in standby without powerup request");
    dbg_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ11
        in_stop |=> o_debug_ap0_reachable) else $error("debug lost in stop");
    dma_stop1_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ10
        (mode == LPMS_STOP1) |-> !auto_act[LPMS_AP_DMA]) else $error("dma active in stop1");
    stop_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ21
        (in_stop && (i_nmi || i_parity_err)) |=> mode == LPMS_RUN)
        else $error("nmi or parity did not wake from stop");
    pin_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ4
        (in_stby && |(i_wakeup_pin & wakeup_pin_en)) |=> mode == LPMS_RUN)
        else $error("wake-up pin ignored in standby");
    pullup_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ14
        i_reset_internal |=> !o_reset_pin_pullup_en) else $error("reset pull-up left on");

    stop_enter_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        mode == LPMS_RUN ##1 mode == LPMS_STOP1 ##[1:20] mode == LPMS_RUN);
    stby_enter_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        mode == LPMS_STBY ##1 mode == LPMS_RUN);
    rc_on_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        in_stop && o_internal_rc_osc_16m_on);

endmodule : lpms_supervisor

// ===== test/lpms_far_model.sv
// far-side model: autonomous peripherals, radio and debugger
`timescale 1ns/1ps

module lpms_far_model
    import lpms_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic [LPMS_NUM_AUTO-1:0] i_osc_cmd,
    input  wire logic [LPMS_NUM_AUTO-1:0] i_evt_cmd,
    input  wire logic                     i_radio_cmd,
    input  wire logic                     i_dbg_cmd,
    output logic [LPMS_NUM_AUTO-1:0]      o_auto_osc_req,
    output logic [LPMS_NUM_AUTO-1:0]      o_auto_event,
    output logic                          o_radio_auto_req,
    output logic                          o_debugger_powerup_request
);
    logic [13:0] pend;

    ////////////////////////////////////////////////////////////////////////////////
    // commands taken on the rising edge, launched on the falling edge,
    // so the supervisor never sees a change at its own sampling edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend <= 14'h0;
        end else begin
            pend <= {i_dbg_cmd, i_radio_cmd, i_evt_cmd, i_osc_cmd};
        end
    end

    // request levels stay up for as long as the command holds them
    always_ff @(negedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_debugger_powerup_request, o_radio_auto_req, o_auto_event, o_auto_osc_req} <= 14'h0;
        end else begin
            o_auto_osc_req             <= pend[5:0];
            o_auto_event               <= pend[11:6];
            o_radio_auto_req           <= pend[12];
            o_debugger_powerup_request <= pend[13];
        end
    end
endmodule : lpms_far_model

// ===== test/tb_low_power_mode_availability_security.sv
// self-checking bench for the power-mode supervisor
`timescale 1ns/1ps

module tb_low_power_mode_availability_security
    import lpms_pkg::*;
;
    logic          i_clk = 1'b0;
    logic          i_rst_n = 1'b0;
    lpms_cfg_type  i_cfg = '0;
    logic          i_rd_secure = 1'b1;
    logic          i_security_enable_option = 1'b0;
    logic          i_sysclk_sel_secure = 1'b0;
    logic [15:0]   i_gpio_secure = 16'h0;
    logic          i_sleep_req = 1'b0;
    logic          i_sw_wake = 1'b0;
    logic [15:0]   i_wakeup_pin = 16'h0;
    logic          i_parity_err = 1'b0;
    logic          i_nmi = 1'b0;
    logic          i_reset_internal = 1'b0;
    logic [5:0]    osc_cmd = 6'h0;
    logic [5:0]    evt_cmd = 6'h0;
    logic          radio_cmd = 1'b0;
    logic          dbg_cmd = 1'b0;
    logic [5:0]    i_auto_osc_req;
    logic [5:0]    i_auto_event;
    logic          i_radio_auto_req;
    logic          i_debugger_powerup_request;
    lpms_mode_type o_mode;
    logic          o_internal_rc_osc_16m_on;
    logic          o_external_xtal_osc_32m_on;
    lpms_auto_type o_auto;
    logic          o_dma_retained;
    logic          o_debug_ap0_reachable;
    logic [15:0]   o_io_analog;
    logic [15:0]   o_io_schmitt_en;
    logic [15:0]   o_io_pull_up;
    logic [15:0]   o_io_pull_down;
    logic          o_reset_pin_pullup_en;
    logic          o_flash_pd;
    logic [1:0]    o_sram_on;
    lpms_cfg_type  o_rd;
    int            errors = 0;
    int            n_compared = 0;

    always #12.5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////////
    lpms_supervisor i_lpms_supervisor (
        .i_clk, .i_rst_n, .i_cfg, .i_rd_secure, .i_security_enable_option, .i_sysclk_sel_secure,
        .i_gpio_secure, .i_sleep_req, .i_sw_wake, .i_auto_osc_req, .i_auto_event, .i_radio_auto_req,
        .i_wakeup_pin, .i_parity_err, .i_nmi, .i_debugger_powerup_request, .i_reset_internal,
        .o_mode, .o_internal_rc_osc_16m_on, .o_external_xtal_osc_32m_on, .o_auto, .o_dma_retained,
        .o_debug_ap0_reachable, .o_io_analog, .o_io_schmitt_en, .o_io_pull_up, .o_io_pull_down,
        .o_reset_pin_pullup_en, .o_flash_pd, .o_sram_on, .o_rd
    );

    lpms_far_model i_lpms_far_model (
        .i_clk, .i_rst_n, .i_osc_cmd(osc_cmd), .i_evt_cmd(evt_cmd), .i_radio_cmd(radio_cmd),
        .i_dbg_cmd(dbg_cmd), .o_auto_osc_req(i_auto_osc_req), .o_auto_event(i_auto_event),
        .o_radio_auto_req(i_radio_auto_req), .o_debugger_powerup_request(i_debugger_powerup_request)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers; every task starts and ends at a falling edge
    task automatic close_out();
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick

    task automatic wcfg(input logic sec);
        i_cfg.secure = sec;
        i_cfg.wr = 1'b1;
        tick(1);
        i_cfg.wr = 1'b0;
        tick(1);
    endtask : wcfg

    // bounded wait; a missed mode change ends the run
    task automatic wait_mode(input lpms_mode_type m);
        int k;
        k = 0;
        while (o_mode !== m && k < 4) begin
            tick(1);
            k++;
        end
        chk(o_mode, m);
        if (o_mode !== m) close_out();
    endtask : wait_mode

    task automatic enter(input logic [2:0] code, input lpms_mode_type m);
        i_cfg.lp_mode = code;
        wcfg(1'b1);
        i_sleep_req = 1'b1;
        wait_mode(m);
    endtask : enter

    task automatic wake();
        i_sleep_req = 1'b0;
        i_sw_wake = 1'b1;
        wait_mode(LPMS_RUN);
        i_sw_wake = 1'b0;
    endtask : wake

    ////////////////////////////////////////////////////////////////////////////////
    // non-secure writes must bounce off locked fields, non-secure reads see zero
    task automatic t_sec();
        i_security_enable_option = 1'b1;
        i_sysclk_sel_secure = 1'b1;
        i_gpio_secure = 16'h0001;
        i_cfg = '{lp_mode: LPMS_SEL_SLEEP, voltage_scaling_select: 2'h1, wakeup_pin_en: 16'hFFFF, ret_en: 16'h0003,
                  pvd_en: 1'b1, bkp_en: 1'b1, default: '0};
        wcfg(1'b1);
        i_cfg = '{lp_mode: LPMS_SEL_STOP0, voltage_scaling_select: 2'h2, sram_on: 2'h3, default: '0};
        wcfg(1'b0);
        tick(2);
        chk(o_rd.lp_mode, LPMS_SEL_SLEEP);
        chk({o_rd.wakeup_pin_en, o_rd.pvd_en, o_rd.bkp_en}, 18'h3FFFF);
        chk(o_rd.voltage_scaling_select, 2'h1);
        chk(o_rd.ret_en, 16'h0001);
        chk(o_rd.sram_on, 2'h3);
        i_rd_secure = 1'b0;
        tick(2);
        chk({o_rd.lp_mode, o_rd.voltage_scaling_select, o_rd.wakeup_pin_en, o_rd.ret_en[0], o_rd.pvd_en, o_rd.bkp_en}, 24'h0);
        i_rd_secure = 1'b1;
        i_security_enable_option = 1'b0;
        i_sysclk_sel_secure = 1'b0;
        i_gpio_secure = 16'h0;
    endtask : t_sec

    // flash power-down only in low-power modes, srams switch alone
    task automatic t_mem();
        i_cfg.flash_pd = 1'b1;
        i_cfg.sram_on = 2'h1;
        wcfg(1'b1);
        tick(2);
        chk(o_sram_on, 2'h1);
        chk(o_flash_pd, 1'b0);
        enter(LPMS_SEL_STOP1, LPMS_STOP1);
        tick(2);
        chk(o_flash_pd, 1'b1);
        wake();
        i_cfg.sram_on = 2'h2;
        wcfg(1'b1);
        tick(2);
        chk(o_sram_on, 2'h2);
    endtask : t_mem

    // dma retained only in deep stop; nmi and parity error both wake
    task automatic t_stop();
        enter(LPMS_SEL_SLEEP, LPMS_SLEEP);
        wake();
        enter(LPMS_SEL_STOP1, LPMS_STOP1);
        tick(2);
        chk({o_dma_retained, o_debug_ap0_reachable}, 2'h3);
        i_nmi = 1'b1;
        wait_mode(LPMS_RUN);
        i_nmi = 1'b0;
        i_sleep_req = 1'b0;
        enter(LPMS_SEL_STOP0, LPMS_STOP0);
        tick(2);
        chk({o_dma_retained, o_debug_ap0_reachable}, 2'h1);
        i_parity_err = 1'b1;
        wait_mode(LPMS_RUN);
        i_parity_err = 1'b0;
        i_sleep_req = 1'b0;
    endtask : t_stop

    // each peripheral alone starts the rc; the radio holds the crystal
    task automatic t_osc();
        i_cfg.auto_en = 6'h3F;
        enter(LPMS_SEL_STOP0, LPMS_STOP0);
        for (int k = 0; k < 6; k++) begin
            osc_cmd = 6'h01 << k;
            tick(3);
            chk(o_internal_rc_osc_16m_on, 1'b1);
            osc_cmd = 6'h0;
            tick(3);
            chk(o_internal_rc_osc_16m_on, 1'b0);
        end
        radio_cmd = 1'b1;
        tick(3);
        chk(o_external_xtal_osc_32m_on, 1'b1);
        radio_cmd = 1'b0;
        tick(3);
        chk(o_external_xtal_osc_32m_on, 1'b0);
        chk(o_auto.run, 6'h3F);
        wake();
    endtask : t_osc

    // transfer events raise wake in deep stop, except the dma
    task automatic t_evt();
        logic seen;
        for (int k = 0; k < 6; k++) begin
            enter(LPMS_SEL_STOP1, LPMS_STOP1);
            evt_cmd = 6'h01 << k;
            seen = 1'b0;
            repeat (5) begin
                tick(1);
                seen = seen | (o_auto.wake[k] === 1'b1);
            end
            chk(seen, k != LPMS_AP_DMA);
            if (k == LPMS_AP_DMA) chk(o_auto.run, 6'h1F);
            evt_cmd = 6'h0;
            wake();
        end
    endtask : t_evt

    // standby pulls, debug gating and all sixteen wake pins
    task automatic t_stby();
        i_cfg.ret_en = 16'h0003;
        i_cfg.ret_pull = 32'h0000_0009;
        i_cfg.wakeup_pin_en = 16'hFFFF;
        enter(LPMS_SEL_STBY, LPMS_STBY);
        chk({o_io_pull_up, o_io_pull_down}, 32'h0001_0002);
        tick(3);
        chk(o_debug_ap0_reachable, 1'b0);
        dbg_cmd = 1'b1;
        tick(3);
        chk(o_debug_ap0_reachable, 1'b1);
        dbg_cmd = 1'b0;
        for (int k = 0; k < 16; k++) begin
            i_wakeup_pin = 16'h0001 << k;
            i_sleep_req = 1'b0;
            wait_mode(LPMS_RUN);
            i_wakeup_pin = 16'h0;
            tick(1);
            enter(k[0] ? LPMS_SEL_STBY_RET : LPMS_SEL_STBY, k[0] ? LPMS_STBY_RET : LPMS_STBY);
        end
        wake();
    endtask : t_stby

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(6);
        chk({o_io_analog, o_io_schmitt_en}, 32'hFFFF_0000);
        chk(o_mode, LPMS_RUN);
        i_rst_n = 1'b1;
        tick(2);
        chk({o_io_analog, o_io_schmitt_en}, 32'hFFFF_0000);
        chk({o_auto.run, o_flash_pd, o_sram_on, o_internal_rc_osc_16m_on}, 10'h0);
        chk(o_reset_pin_pullup_en, 1'b1);
        i_reset_internal = 1'b1;
        tick(2);
        chk(o_reset_pin_pullup_en, 1'b0);
        i_reset_internal = 1'b0;
        t_sec();
        t_mem();
        t_stop();
        t_osc();
        t_evt();
        t_stby();
        i_rst_n = 1'b0;
        tick(1);
        chk({o_io_analog, o_io_schmitt_en}, 32'hFFFF_0000);
        close_out();
    end
endmodule : tb_low_power_mode_availability_security
